// >>> rtl/dbu_pkg.sv
// Purpose: Constants for the doorbell message unit
// Assumes: 32-bit classic Wishbone, word-aligned byte addresses
// Notes: Offsets are byte addresses of 32-bit registers
package dbu_pkg;
	localparam int DBU_RX_DEPTH = 16;
	localparam int DBU_TX_DEPTH = 16;
	localparam int DBU_MSG_W = 16;
	localparam int DBU_LVL_W = 5;
	localparam int DBU_ADR_W = 8;
	localparam int DBU_TX_W = 18;

	localparam logic [7:0] DBU_OFF_RX_DATA = 8'h00;
	localparam logic [7:0] DBU_OFF_RX_STAT = 8'h04;
	localparam logic [7:0] DBU_OFF_TX_CTRL = 8'h08;
	localparam logic [7:0] DBU_OFF_TX_DATA = 8'h0C;
	localparam logic [7:0] DBU_OFF_TX_STAT = 8'h10;
	localparam logic [7:0] DBU_OFF_IRQ_STAT = 8'h14;
	localparam logic [7:0] DBU_OFF_IRQ_EN = 8'h18;
	localparam logic [7:0] DBU_OFF_IRQ_CLR = 8'h1C;

	// Interrupt bit layout
	localparam int DBU_IRQ_RX = 0;
	localparam int DBU_IRQ_OVR = 1;
	localparam int DBU_IRQ_W = 2;
	localparam logic [1:0] DBU_IRQ_EN_RST = 2'h3;

	// Tx control bit: keep successful completion records
	localparam int DBU_CTRL_KEEP = 0;
	localparam logic DBU_CTRL_KEEP_RST = 1'b1;

	localparam logic [31:0] DBU_ZERO = 32'h0000_0000;
endpackage

// >>> rtl/dbu_doorbell_unit.sv
// Purpose: Doorbell message unit with Rx queue and Tx completion buffer
// Assumes: Single clock, synchronous active-high reset, classic Wishbone
// Notes: Wishbone ack comes one cycle after the request is seen
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module dbu_doorbell_unit import dbu_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [DBU_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rx_valid_i,
	input wire logic [DBU_MSG_W-1:0] rx_msg_i,
	output logic rx_ready_o,
	input wire logic done_valid_i,
	input wire logic done_ok_i,
	input wire logic [DBU_MSG_W-1:0] done_msg_i,
	output logic irq_o
);
	// -----------------------------------------------------------------
	// Storage
	// -----------------------------------------------------------------
	logic [DBU_MSG_W-1:0] rx_mem_r [DBU_RX_DEPTH];
	logic [DBU_MSG_W-1:0] rx_mem_nxt [DBU_RX_DEPTH];
	logic [3:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
	logic [DBU_LVL_W-1:0] rx_lvl_r, rx_lvl_nxt;
	logic [DBU_TX_W-1:0] tx_mem_r [DBU_TX_DEPTH];
	logic [DBU_TX_W-1:0] tx_mem_nxt [DBU_TX_DEPTH];
	logic [3:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
	logic [DBU_LVL_W-1:0] tx_lvl_r, tx_lvl_nxt;
	logic keep_success_records_r, keep_success_records_nxt;
	logic tx_done_overrun_r, tx_done_overrun_nxt;
	logic [DBU_IRQ_W-1:0] irq_en_r, irq_en_nxt;
	logic irq_r, irq_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic rx_ready_r, rx_ready_nxt;

	function automatic logic [DBU_LVL_W-1:0] lvl_step(
		input logic [DBU_LVL_W-1:0] lvl, input logic inc, input logic dec);
		logic [DBU_LVL_W-1:0] r;
		r = lvl;
		if (inc && !dec) begin
			r = lvl + 5'h01;
		end else if (dec && !inc) begin
			r = lvl - 5'h01;
		end
		return r;
	endfunction

	// -----------------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------------
	logic req, wr, rd, rx_push, rx_pop, tx_store, tx_pop, tx_full;
	logic [DBU_IRQ_W-1:0] stat;

	always_comb begin
		req = wb_cyc_i && wb_stb_i && !ack_r;
		wr = req && wb_we_i && wb_sel_i[0];
		rd = req && !wb_we_i;
		rx_mem_nxt = rx_mem_r;
		tx_mem_nxt = tx_mem_r;
		rx_push = rx_valid_i && rx_ready_r;
		rx_pop = rd && (wb_adr_i == DBU_OFF_RX_DATA) && (rx_lvl_r != 5'h00);
		tx_pop = rd && (wb_adr_i == DBU_OFF_TX_DATA) && (tx_lvl_r != 5'h00);
		tx_full = (tx_lvl_r == DBU_TX_DEPTH[DBU_LVL_W-1:0]);
		tx_store = done_valid_i && (!done_ok_i || keep_success_records_r);
		rx_wp_nxt = rx_wp_r;
		rx_rp_nxt = rx_rp_r;
		tx_wp_nxt = tx_wp_r;
		tx_rp_nxt = tx_rp_r;
		if (rx_push) begin
			rx_mem_nxt[rx_wp_r] = rx_msg_i;
			rx_wp_nxt = rx_wp_r + 4'h1;
		end
		if (rx_pop) begin
			rx_rp_nxt = rx_rp_r + 4'h1;
		end
		// A full buffer drops the record; a same-cycle read frees a slot
		if (tx_store && (!tx_full || tx_pop)) begin
			tx_mem_nxt[tx_wp_r] = {done_ok_i, 1'b1, done_msg_i};
			tx_wp_nxt = tx_wp_r + 4'h1;
		end
		if (tx_pop) begin
			tx_rp_nxt = tx_rp_r + 4'h1;
		end
		// Push and pop counted together, never lost
		rx_lvl_nxt = lvl_step(rx_lvl_r, rx_push, rx_pop);
		tx_lvl_nxt = lvl_step(tx_lvl_r, tx_store && (!tx_full || tx_pop), tx_pop);
		rx_ready_nxt = (rx_lvl_nxt < DBU_RX_DEPTH[DBU_LVL_W-1:0]);

		keep_success_records_nxt = keep_success_records_r;
		irq_en_nxt = irq_en_r;
		tx_done_overrun_nxt = tx_done_overrun_r;
		if (wr && wb_adr_i == DBU_OFF_TX_CTRL) begin
			keep_success_records_nxt = wb_dat_i[DBU_CTRL_KEEP];
		end
		if (wr && wb_adr_i == DBU_OFF_IRQ_EN) begin
			irq_en_nxt = wb_dat_i[DBU_IRQ_W-1:0];
		end
		if (wr && wb_adr_i == DBU_OFF_IRQ_CLR && wb_dat_i[DBU_IRQ_OVR]) begin
			tx_done_overrun_nxt = 1'b0;
		end
		if (tx_store && tx_full && !tx_pop) begin
			tx_done_overrun_nxt = 1'b1;
		end

		// Rx status is the live level, immune to push/pop races
		stat = {tx_done_overrun_nxt, rx_lvl_nxt != 5'h00};
		irq_nxt = |(stat & irq_en_nxt);

		ack_nxt = req;
		dat_nxt = DBU_ZERO;
		if (rd) begin
			case (wb_adr_i)
				DBU_OFF_RX_DATA: begin
					// Empty queue reads as zero, never stale storage
					dat_nxt = (rx_lvl_r != 5'h00) ?
						{15'h0000, 1'b1, rx_mem_r[rx_rp_r]} : DBU_ZERO;
				end
				DBU_OFF_RX_STAT: begin
					dat_nxt = {27'h0000000, rx_lvl_r};
				end
				DBU_OFF_TX_CTRL: begin
					dat_nxt = {31'h00000000, keep_success_records_r};
				end
				DBU_OFF_TX_DATA: begin
					dat_nxt = (tx_lvl_r != 5'h00) ?
						{14'h0000, tx_mem_r[tx_rp_r]} : DBU_ZERO;
				end
				DBU_OFF_TX_STAT: begin
					dat_nxt = {27'h0000000, tx_lvl_r};
				end
				DBU_OFF_IRQ_STAT: begin
					dat_nxt = {30'h00000000, tx_done_overrun_r, rx_lvl_r != 5'h00};
				end
				DBU_OFF_IRQ_EN: begin
					dat_nxt = {30'h00000000, irq_en_r};
				end
				default: begin
					dat_nxt = DBU_ZERO;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	// Queue storage: contents only matter below the level, so no reset
	always_ff @(posedge clk_i) begin
		rx_mem_r <= rx_mem_nxt;
		tx_mem_r <= tx_mem_nxt;
	end

	// -----------------------------------------------------------------
	// Rx queue pointers, level and ready
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_wp_r <= 4'h0;
			rx_rp_r <= 4'h0;
			rx_lvl_r <= 5'h00;
			rx_ready_r <= 1'b0;
		end else begin
			rx_wp_r <= rx_wp_nxt;
			rx_rp_r <= rx_rp_nxt;
			rx_lvl_r <= rx_lvl_nxt;
			rx_ready_r <= rx_ready_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Tx completion buffer pointers and level
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_wp_r <= 4'h0;
			tx_rp_r <= 4'h0;
			tx_lvl_r <= 5'h00;
		end else begin
			tx_wp_r <= tx_wp_nxt;
			tx_rp_r <= tx_rp_nxt;
			tx_lvl_r <= tx_lvl_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Control, overrun flag and interrupt
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			keep_success_records_r <= DBU_CTRL_KEEP_RST;
			tx_done_overrun_r <= 1'b0;
			irq_en_r <= DBU_IRQ_EN_RST;
			irq_r <= 1'b0;
		end else begin
			keep_success_records_r <= keep_success_records_nxt;
			tx_done_overrun_r <= tx_done_overrun_nxt;
			irq_en_r <= irq_en_nxt;
			irq_r <= irq_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Bus answer
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= DBU_ZERO;
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
	assign rx_ready_o = rx_ready_r;
	assign irq_o = irq_r;
endmodule
`default_nettype wire

// >>> bench/dbu_props.sv
// Purpose: Port checks for the doorbell unit
// Assumes: Bound to dbu_doorbell_unit
// Notes: Enable copy follows IRQ_EN writes
`timescale 1ns/10ps
`default_nettype none
module dbu_props import dbu_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [DBU_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic rx_valid_i,
	input wire logic rx_ready_o,
	input wire logic irq_o
);
	logic [1:0] en_r, en_nxt;
	always_comb begin
		en_nxt = en_r;
		if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == DBU_OFF_IRQ_EN)
			en_nxt = wb_dat_i[1:0];
	end
	always_ff @(posedge clk_i)
		en_r <= rst_i ? DBU_IRQ_EN_RST : en_nxt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == DBU_ZERO)
		else $error("read data without ack");
	a_ready_up: assert property ($fell(rst_i) |=> rx_ready_o)
		else $error("ready late after reset");
	a_rx_irq: assert property (rx_valid_i && rx_ready_o && en_nxt[DBU_IRQ_RX]
		|=> irq_o) else $error("irq low with message held");
	a_irq_masked: assert property (en_nxt == 2'h0 |=> !irq_o)
		else $error("irq while masked");
endmodule
bind dbu_doorbell_unit dbu_props i_props(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.rx_valid_i, .rx_ready_o, .irq_o);
`default_nettype wire

// >>> bench/dbu_link_model.sv
// Purpose: Transport side model: doorbells in, completions
// Assumes: Same clock as the unit
// Notes: Idle data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module dbu_link_model import dbu_pkg::*; (
	input wire logic clk_i,
	input wire logic rx_ready_i,
	output logic rx_valid_o = 0,
	output logic [DBU_MSG_W-1:0] rx_msg_o = 0,
	output logic done_valid_o = 0,
	output logic done_ok_o = 0,
	output logic [DBU_MSG_W-1:0] done_msg_o = 0
);
	task automatic push(input logic [DBU_MSG_W-1:0] m);
		@(posedge clk_i);
		{rx_valid_o, rx_msg_o} <= {1'b1, m};
		do @(posedge clk_i); while (rx_ready_i !== 1'b1);
		{rx_valid_o, rx_msg_o} <= {1'b0, ~m};
	endtask
	task automatic done(input logic ok, input logic [DBU_MSG_W-1:0] m);
		@(posedge clk_i);
		{done_valid_o, done_ok_o, done_msg_o} <= {2'b11 & {1'b1, ok}, m};
		@(posedge clk_i);
		{done_valid_o, done_ok_o, done_msg_o} <= {1'b0, ~ok, ~m};
	endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: Register level test of the doorbell unit
// Assumes: Classic Wishbone, one clock
// Notes: Overflow is forced by sending one record too many
`timescale 1ns/10ps
`default_nettype none
module tb_top import dbu_pkg::*;;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq, rdy;
	logic rxv, dv, dok;
	logic [7:0] adr = 0;
	logic [31:0] wd = 0, rd;
	logic [15:0] rxm, dm;
	int err_count = 0, n_compared = 0;
	always #5 clk_i = ~clk_i;
	dbu_doorbell_unit i_dut(.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_ack_o(ack), .rx_valid_i(rxv), .rx_msg_i(rxm),
		.rx_ready_o(rdy), .done_valid_i(dv), .done_ok_i(dok),
		.done_msg_i(dm), .irq_o(irq));
	dbu_link_model i_link(.clk_i, .rx_ready_i(rdy), .rx_valid_o(rxv),
		.rx_msg_o(rxm), .done_valid_o(dv), .done_ok_o(dok), .done_msg_o(dm));
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		{cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rd;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic irqc(input logic e);
		@(negedge clk_i);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task finish_test;
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		finish_test;
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		rdc(DBU_OFF_IRQ_EN, 32'h3);
		rdc(DBU_OFF_TX_CTRL, 32'h1);
		rdc(8'h20, 32'h0);
		i_link.push(16'h1111);
		irqc(1'b1);
		fork
			i_link.push(16'hA5A5);
			rdc(DBU_OFF_RX_DATA, 32'h1_1111);
		join
		irqc(1'b1);
		i_link.push(16'h2222);
		rdc(DBU_OFF_RX_STAT, 32'h2);
		rdc(DBU_OFF_RX_DATA, 32'h1_A5A5);
		rdc(DBU_OFF_RX_DATA, 32'h1_2222);
		rdc(DBU_OFF_RX_STAT, 32'h0);
		rdc(DBU_OFF_RX_DATA, 32'h0);
		irqc(1'b0);
		wr(DBU_OFF_TX_CTRL, 32'h0);
		i_link.done(1'b1, 16'h0101);
		i_link.done(1'b0, 16'h0202);
		rdc(DBU_OFF_TX_STAT, 32'h1);
		rdc(DBU_OFF_TX_DATA, 32'h1_0202);
		wr(DBU_OFF_TX_CTRL, 32'h1);
		for (int i = 0; i <= DBU_TX_DEPTH; i++)
			i_link.done(1'b1, 16'(i));
		rdc(DBU_OFF_IRQ_STAT, 32'h2);
		irqc(1'b1);
		wr(DBU_OFF_IRQ_EN, 32'h1);
		irqc(1'b0);
		wr(DBU_OFF_IRQ_EN, 32'h0);
		rdc(DBU_OFF_IRQ_STAT, 32'h2);
		wr(DBU_OFF_IRQ_EN, 32'h3);
		wr(DBU_OFF_IRQ_CLR, 32'h2);
		rdc(DBU_OFF_IRQ_STAT, 32'h0);
		irqc(1'b0);
		i_link.done(1'b0, 16'hBEEF);
		rdc(DBU_OFF_IRQ_STAT, 32'h2);
		rdc(DBU_OFF_TX_DATA, 32'h3_0000);
		for (int i = 0; i < DBU_RX_DEPTH; i++)
			i_link.push(16'(i));
		rdc(DBU_OFF_RX_STAT, 32'h10);
		@(negedge clk_i);
		chk({31'h0, rdy}, 32'h0);
		for (int i = 0; i < DBU_RX_DEPTH; i++)
			rdc(DBU_OFF_RX_DATA, 32'h0001_0000 | i);
		rdc(DBU_OFF_RX_STAT, 32'h0);
		finish_test;
	end
endmodule
`default_nettype wire
